//--- rtl/irqesl_dummy_never.sv
// Spare design unit slot; the logic sits in irqesl_top, apart from the address decode in irqesl_pkg.

//--- rtl/irqesl_pkg.sv
// Shared constants for the interrupt enable and status block.
package irqesl_pkg;

  // Bus widths.
  localparam int ADDR_W = 6;
  localparam int DATA_W = 32;

  // Register byte offsets, one aligned word each.
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_PORT_A = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_PORT_B = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_NMI_EN = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_NMI_ST = 6'h14;

  // Maskable source positions in enable and status registers.
  localparam int BIT_TIMER1 = 0;
  localparam int BIT_TIMER2 = 1;
  localparam int BIT_TIMER4 = 2;
  localparam int BIT_XMIT   = 3;
  localparam int BIT_SEROUT = 4;
  localparam int BIT_SERIN  = 5;
  localparam int BIT_KEY    = 6;
  localparam int BIT_BREAK  = 7;
  localparam int SRC_W      = 8;

  // Parallel-port control register fields.
  localparam int PCTL_EN_BIT   = 0;
  localparam int PCTL_FLAG_BIT = 7;
  localparam int PCTL_W        = 8;
  localparam int PORTS         = 2;
  localparam int PORT_A        = 0;
  localparam int PORT_B        = 1;

  // Nonmaskable source positions.
  localparam int NMI_DLI = 0;
  localparam int NMI_VBL = 1;
  localparam int NMI_RST = 2;
  localparam int NMI_W   = 3;

  // Reset values.
  localparam logic [SRC_W-1:0]  IRQ_EN_RST = 8'h00;
  localparam logic [SRC_W-1:0]  IRQ_ST_RST = 8'h00;
  localparam logic [PCTL_W-2:0] PCTL_RST   = 7'h00;
  localparam logic [NMI_W-1:0]  NMI_EN_RST = 3'h0;
  localparam logic [NMI_W-1:0]  NMI_ST_RST = 3'h0;

  // Bus response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Register selected by an address.
  typedef enum {
    REG_IRQ_EN, REG_IRQ_ST, REG_PORT_A, REG_PORT_B,
    REG_NMI_EN, REG_NMI_ST, REG_NONE
  } irqesl_reg_t;

  // Word-aligned address decode, shared by the read and write paths.
  function automatic irqesl_reg_t irqesl_decode(
    input logic [ADDR_W-1:0] a
  );
    logic [ADDR_W-1:0] w;
    w = {a[ADDR_W-1:2], 2'h0};
    case (w)
      OFS_IRQ_EN: irqesl_decode = REG_IRQ_EN;
      OFS_IRQ_ST: irqesl_decode = REG_IRQ_ST;
      OFS_PORT_A: irqesl_decode = REG_PORT_A;
      OFS_PORT_B: irqesl_decode = REG_PORT_B;
      OFS_NMI_EN: irqesl_decode = REG_NMI_EN;
      OFS_NMI_ST: irqesl_decode = REG_NMI_ST;
      default:    irqesl_decode = REG_NONE;
    endcase
  endfunction

endpackage

//--- rtl/irqesl_top.sv
module irqesl_top (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [irqesl_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  input  wire logic [irqesl_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  output logic [1:0]                          s_axi_bresp,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  input  wire logic [irqesl_pkg::ADDR_W-1:0]  s_axi_araddr,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  output logic [irqesl_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  input  wire logic                           serin_evt,
  input  wire logic                           serout_evt,
  input  wire logic                           xmit_done,
  input  wire logic                           timer1_evt,
  input  wire logic                           timer2_evt,
  input  wire logic                           timer4_evt,
  input  wire logic                           key_evt,
  input  wire logic                           break_evt,
  input  wire logic                           proceed_pin,
  input  wire logic                           periph_int_pin,
  input  wire logic                           dli_evt,
  input  wire logic                           vblank_evt,
  input  wire logic                           sys_reset_pin,
  output logic                                irq_o,
  output logic                                nmi_o
);
  import irqesl_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic [SRC_W-1:0]  irq_en_r;        // Write-only source enables.
  logic [SRC_W-1:0]  irq_st_r;        // Sticky pending flags.
  logic [SRC_W-1:0]  irq_st_view;     // Flags as software sees them.
  logic [SRC_W-1:0]  src_evt;         // Event pulses by bit position.
  logic [PCTL_W-2:0] port_ctl_r [PORTS]; // Stored port control bits.
  logic [PORTS-1:0]  port_flag_r;     // Port interrupt flags.
  logic [PORTS-1:0]  port_edge;       // Port input request edges.
  logic [PORTS-1:0]  port_rd;         // Port control read this cycle.
  logic [NMI_W-1:0]  nmi_en_r;        // Nonmaskable source enables.
  logic [NMI_W-1:0]  nmi_st_r;        // Nonmaskable sticky flags.
  logic [NMI_W-1:0]  nmi_evt;         // Nonmaskable event pulses.
  logic [2:0]        sync1_r;         // First synchroniser stage.
  logic [2:0]        sync2_r;         // Second synchroniser stage.
  logic [2:0]        sync3_r;         // Third synchroniser stage.
  logic [2:0]        pin_lvl_r;       // Accepted pin levels.
  logic [2:0]        pin_rise;        // Accepted rising edges.
  logic              aw_full_r;       // Write address held.
  logic              w_full_r;        // Write data held.
  logic [ADDR_W-1:0] aw_addr_r;       // Held write address.
  logic [DATA_W-1:0] w_data_r;        // Held write data.
  logic              w_lane0_r;       // Low byte lane was strobed.
  logic              do_wr;           // Write performed this cycle.
  logic              wr_ok;           // Write changes a register.
  irqesl_reg_t       wr_sel;          // Register being written.
  irqesl_reg_t       rd_sel;          // Register being read.
  logic              rd_take;         // Read address taken.
  logic              bvalid_r;        // Write response pending.
  logic [1:0]        bresp_r;         // Write response code.
  logic              rvalid_r;        // Read response pending.
  logic [DATA_W-1:0] rdata_r;         // Read data.
  logic [1:0]        rresp_r;         // Read response code.
  logic [DATA_W-1:0] rd_val;          // Value for the current read.

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The serial-bus lines and the reset key come from
  // outside the clock domain; a level counts only once stages two and
  // three agree, which rejects a single-cycle glitch.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r   <= 3'h0;
      sync2_r   <= 3'h0;
      sync3_r   <= 3'h0;
      pin_lvl_r <= 3'h0;
    end else begin
      sync1_r <= {sys_reset_pin, periph_int_pin, proceed_pin};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      for (int i = 0; i < 3; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          pin_lvl_r[i] <= sync3_r[i];
        end
      end
    end
  end

  // Edge seen when stages two and three agree high over a low level.
  assign pin_rise = sync2_r & sync3_r & ~pin_lvl_r;

  assign port_edge[PORT_A] = pin_rise[0];
  assign port_edge[PORT_B] = pin_rise[1];

  //////////////////////////////////////////////////////////////////////////
  // Maskable sources, gathered by bit position.
  // Keyboard and break are distinct bits; serial and timers one each.
  always_comb begin
    src_evt             = '0;
    src_evt[BIT_TIMER1] = timer1_evt;
    src_evt[BIT_TIMER2] = timer2_evt;
    src_evt[BIT_TIMER4] = timer4_evt;
    src_evt[BIT_SEROUT] = serout_evt;
    src_evt[BIT_SERIN]  = serin_evt;
    src_evt[BIT_KEY]    = key_evt;
    src_evt[BIT_BREAK]  = break_evt;
  end

  // Bit 3 is not a latch: it mirrors the transmit shift register.
  always_comb begin
    irq_st_view            = irq_st_r;
    irq_st_view[BIT_XMIT]  = xmit_done;
  end

  //////////////////////////////////////////////////////////////////////////
  // Write channel. Address and data are taken independently; the
  // register update happens once both are held and no response waits.
  assign s_axi_awready = !aw_full_r;
  assign s_axi_wready  = !w_full_r;
  assign do_wr  = aw_full_r && w_full_r && !bvalid_r;
  assign wr_sel = irqesl_decode(aw_addr_r);
  // Registers are at most eight bits wide, so only byte lane 0 writes.
  assign wr_ok  = do_wr && w_lane0_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r  <= 1'b0;
      w_data_r  <= '0;
      w_lane0_r <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_r  <= 1'b1;
      w_data_r  <= s_axi_wdata;
      w_lane0_r <= s_axi_wstrb[0];
    end else if (do_wr) begin
      w_full_r <= 1'b0;
    end
  end

  // Unmapped writes answer with a decode error and change nothing.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wr_sel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  //////////////////////////////////////////////////////////////////////////
  // Read channel. One read at a time; data appear one edge after the
  // address is taken. Port control reads clear the port flag.
  assign s_axi_arready = !rvalid_r;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign rd_sel  = irqesl_decode(s_axi_araddr);
  assign port_rd[PORT_A] = rd_take && (rd_sel == REG_PORT_A);
  assign port_rd[PORT_B] = rd_take && (rd_sel == REG_PORT_B);

  // Read data mux; the enable register hides its contents.
  always_comb begin
    rd_val = '0;
    case (rd_sel)
      REG_IRQ_EN: rd_val = '0;
      REG_IRQ_ST: rd_val[SRC_W-1:0] = irq_st_view;
      REG_PORT_A: rd_val[PCTL_W-1:0] = {port_flag_r[PORT_A],
                                        port_ctl_r[PORT_A]};
      REG_PORT_B: rd_val[PCTL_W-1:0] = {port_flag_r[PORT_B],
                                        port_ctl_r[PORT_B]};
      REG_NMI_EN: rd_val[NMI_W-1:0] = nmi_en_r;
      REG_NMI_ST: rd_val[NMI_W-1:0] = nmi_st_r;
      default:    rd_val = '0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OKAY;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_val;
      rresp_r  <= (rd_sel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

  //////////////////////////////////////////////////////////////////////////
  // Maskable enable and status registers.
  // A one enables the source.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_r <= IRQ_EN_RST;
    end else if (wr_ok && wr_sel == REG_IRQ_EN) begin
      irq_en_r <= w_data_r[SRC_W-1:0];
    end
  end

  // Only an enabled source latches; a zero written to the enable clears
  // the flag. A new event in the clearing cycle still sets the flag.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_r <= IRQ_ST_RST;
    end else begin
      for (int i = 0; i < SRC_W; i++) begin
        if (i == BIT_XMIT) begin
          irq_st_r[i] <= 1'b0;
        end else if (src_evt[i] && irq_en_r[i]) begin
          irq_st_r[i] <= 1'b1;
        end else if (wr_ok && wr_sel == REG_IRQ_EN && !w_data_r[i]) begin
          irq_st_r[i] <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Parallel-port control registers. Bits 6..0 are stored; bit 7 is the
  // flag, set by an input edge and cleared by a read of the register; an edge in the same cycle wins.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_ctl_r  <= '{default: PCTL_RST};
      port_flag_r <= '0;
    end else begin
      if (wr_ok && wr_sel == REG_PORT_A) begin
        port_ctl_r[PORT_A] <= w_data_r[PCTL_W-2:0];
      end
      if (wr_ok && wr_sel == REG_PORT_B) begin
        port_ctl_r[PORT_B] <= w_data_r[PCTL_W-2:0];
      end
      for (int p = 0; p < PORTS; p++) begin
        if (port_edge[p]) begin
          port_flag_r[p] <= 1'b1;
        end else if (port_rd[p]) begin
          port_flag_r[p] <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Maskable request output. It is a level that follows the flags, so it
  // falls as soon as the last enabled flag is cleared. The processor's
  // own global disable lies outside and is not modelled here.
  always_comb begin
    irq_o = |(irq_st_view & irq_en_r);
    for (int p = 0; p < PORTS; p++) begin
      irq_o = irq_o || (port_flag_r[p]
              && port_ctl_r[p][PCTL_EN_BIT]);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Nonmaskable path. Display-list and vertical-blank events need their
  // enable; the reset key is always enabled. Flags clear by writing one.
  assign nmi_evt[NMI_DLI] = dli_evt;
  assign nmi_evt[NMI_VBL] = vblank_evt;
  assign nmi_evt[NMI_RST] = pin_rise[2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_en_r <= NMI_EN_RST;
    end else if (wr_ok && wr_sel == REG_NMI_EN) begin
      nmi_en_r <= w_data_r[NMI_W-1:0];
    end
  end

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_st_r <= NMI_ST_RST;
    end else begin
      for (int i = 0; i < NMI_W; i++) begin
        if (nmi_evt[i]) begin
          nmi_st_r[i] <= 1'b1;
        end else if (wr_ok && wr_sel == REG_NMI_ST && w_data_r[i]) begin
          nmi_st_r[i] <= 1'b0;
        end
      end
    end
  end

  // The reset bit bypasses the enable register.
  always_comb begin
    nmi_o = nmi_st_r[NMI_RST]
            || |(nmi_st_r[NMI_VBL:NMI_DLI]
                 & nmi_en_r[NMI_VBL:NMI_DLI]);
  end

  //////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence en_write_s;
    wr_ok && wr_sel == REG_IRQ_EN;
  endsequence
  sequence port_a_read_s;
    port_rd[PORT_A] && !port_edge[PORT_A];
  endsequence
  key_raise_a: assert property (
    key_evt && irq_en_r[BIT_KEY] && !(wr_ok && wr_sel == REG_IRQ_EN)
    |=> irq_st_r[BIT_KEY] && irq_o)
    else $error("enabled key press did not raise a request");
  key_off_a: assert property (
    !irq_en_r[BIT_KEY] && !irq_st_r[BIT_KEY] |=> !irq_st_r[BIT_KEY])
    else $error("disabled keyboard raised a flag");
  brk_alone_a: assert property (
    break_evt && irq_en_r[BIT_BREAK] && !irq_en_r[BIT_KEY]
    |=> irq_st_r[BIT_BREAK])
    else $error("break key not raised with keyboard off");
  zero_clear_a: assert property (
    en_write_s ##0 (!w_data_r[BIT_TIMER1] && !timer1_evt)
    |=> !irq_st_r[BIT_TIMER1] [*2])
    else $error("zero written to enable left status set");
  en_write_a: assert property (
    en_write_s |=> irq_en_r == $past(w_data_r[SRC_W-1:0]))
    else $error("enable register not loaded");
  wo_read_a: assert property (
    rd_take && rd_sel == REG_IRQ_EN |=> s_axi_rvalid && s_axi_rdata == '0)
    else $error("enable register read back its contents");
  live_xmit_a: assert property (
    rd_take && rd_sel == REG_IRQ_ST
    |=> s_axi_rdata[BIT_XMIT] == $past(xmit_done))
    else $error("transmit bit not live");
  flag_clear_a: assert property (
    port_a_read_s |=> !port_flag_r[PORT_A])
    else $error("port read did not clear its flag");
  port_irq_a: assert property (
    port_flag_r[PORT_B] && port_ctl_r[PORT_B][PCTL_EN_BIT] |-> irq_o)
    else $error("enabled port flag gave no request");
  gate_off_a: assert property (
    irq_en_r == '0 && !port_ctl_r[PORT_A][PCTL_EN_BIT]
    && !port_ctl_r[PORT_B][PCTL_EN_BIT] |-> !irq_o)
    else $error("request with every source disabled");
  irq_drop_a: assert property (
    en_write_s ##0 (w_data_r[SRC_W-1:0] == '0)
    ##0 !(port_ctl_r[PORT_A][PCTL_EN_BIT] || port_ctl_r[PORT_B][PCTL_EN_BIT])
    |=> !irq_o)
    else $error("request held with nothing pending");
  reset_nmi_a: assert property (
    pin_rise[2] |=> nmi_o ##1 nmi_o)
    else $error("reset key did not reach the processor");
  write_resp_a: assert property (
    do_wr |=> s_axi_bvalid)
    else $error("write gave no response");
endmodule

//--- tb/irqesl_host.sv
// Behavioural host core that receives the request lines.
module irqesl_host (
  input  wire logic aclk,
  input  wire logic irq,
  input  wire logic nmi,
  input  wire logic global_irq_enable,
  output logic      take_irq,
  output logic      take_nmi
);
  timeunit 1ns;
  timeprecision 1ns;
  // The core gates every maskable request with its one global flag.
  always_ff @(posedge aclk) take_irq <= irq & global_irq_enable;
  // Nonmaskable requests are never gated inside the core.
  always_ff @(posedge aclk) take_nmi <= nmi;
endmodule

//--- tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import irqesl_pkg::*;
  // Bench-driven inputs, changed by NBA right after a rising edge.
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [5:0]  awaddr, araddr, ad;
  logic [31:0] wdata, lf;
  logic [9:0]  evt;
  logic [2:0]  pins;
  logic        xmit, gie;
  // Design and host outputs.
  logic        awready, wready, bvalid, arready, rvalid, irq, nmi, tk_i;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  v;
  // Notes of expected responses, oldest first.
  logic [33:0] rq[$], er;
  logic [1:0]  bq[$];
  int          fails, tests_run;
  ////////////////////////////////////////////////////////////////////////
  irqesl_top DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .timer1_evt(evt[0]), .timer2_evt(evt[1]),
    .timer4_evt(evt[2]), .xmit_done(xmit), .serout_evt(evt[4]),
    .serin_evt(evt[5]), .key_evt(evt[6]), .break_evt(evt[7]),
    .dli_evt(evt[8]), .vblank_evt(evt[9]), .proceed_pin(pins[0]),
    .periph_int_pin(pins[1]), .sys_reset_pin(pins[2]), .irq_o(irq),
    .nmi_o(nmi));
  irqesl_host HOST (.aclk(aclk), .irq(irq), .nmi(nmi),
    .global_irq_enable(gie), .take_irq(tk_i), .take_nmi());
  ////////////////////////////////////////////////////////////////////////
  // Free-running bench clock of 40 ns.
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Next value of the stimulus shift register.
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic err(input string s, input logic [33:0] e, g);
    fails++;
    $display("ERROR %s expected %h seen %h", s, e, g);
  endtask
  // A wait that runs too long ends the run as a mismatch.
  task automatic tmo(input int n);
    if (n > 60) begin
      err("handshake", 34'h1, 34'h0);
      stop_test();
    end
  endtask
  // Write one word; both channels are offered together.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    int   n;
    logic ga, gw;
    n = 0;
    ga = 1'b0;
    gw = 1'b0;
    bq.push_back(a < 6'h18 ? RESP_OKAY : RESP_DECERR);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (awvalid && awready) ga = 1'b1;
      if (wvalid && wready) gw = 1'b1;
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
      n++;
      tmo(n);
    end
    while (!bvalid) begin
      @(posedge aclk);
      n++;
      tmo(n);
    end
    bready <= 1'b0;
  endtask
  // Read one word and note the expected data and response.
  task automatic rd(input logic [5:0] a, input logic [7:0] d);
    int n;
    n = 0;
    rq.push_back({a < 6'h18 ? RESP_OKAY : RESP_DECERR, 24'h000000, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      tmo(n);
    end while (!arready);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
      tmo(n);
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  // One-cycle pulse on an event input.
  task automatic pulse(input int b);
    @(posedge aclk);
    evt <= 10'h001 << b;
    @(posedge aclk);
    evt <= 10'h000;
  endtask
  // Hold a pin high long enough for its edge to be seen.
  task automatic pin(input int p);
    @(posedge aclk);
    pins <= 3'h1 << p;
    repeat (6) @(posedge aclk);
    pins <= 3'h0;
  endtask
  // Compare both request lines one edge later.
  task automatic ck(input logic ei, input logic en);
    @(posedge aclk);
    tests_run += 2;
    if (irq !== ei) err("irq_o", ei, irq);
    if (nmi !== en) err("nmi_o", en, nmi);
  endtask
  // Watcher: every answer takes the oldest note off its queue.
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      tests_run++;
      er = rq.pop_front();
      if ({rresp, rdata} !== er) err("read", er, {rresp, rdata});
    end
    if (bvalid && bready) begin
      tests_run++;
      er = bq.pop_front();
      if (bresp !== er[1:0]) err("bresp", er, bresp);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, xmit} = '0;
    {awaddr, araddr, wdata, evt, pins} = '0;
    {fails, tests_run} = '0;
    gie = 1'b1;
    lf = 32'h51A8942C;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wr(OFS_IRQ_EN, 8'hFF);
    rd(OFS_IRQ_EN, 8'h00);
    wr(OFS_IRQ_EN, 8'h00);
    // Every maskable event except transmit-finished, first disabled, then enabled, then cleared.
    for (int b = 0; b < 8; b++) begin
      if (b == BIT_XMIT) continue;
      pulse(b);
      ck(1'b0, 1'b0);
      wr(OFS_IRQ_EN, 8'h01 << b);
      pulse(b);
      rd(OFS_IRQ_ST, 8'h01 << b);
      ck(1'b1, 1'b0);
      wr(OFS_IRQ_EN, 8'h00);
      rd(OFS_IRQ_ST, 8'h00);
      ck(1'b0, 1'b0);
    end
    wr(OFS_IRQ_EN, 8'h80);
    pulse(BIT_KEY);
    ck(1'b0, 1'b0);
    pulse(BIT_BREAK);
    rd(OFS_IRQ_ST, 8'h80);
    // Transmit-finished stays live when its enable is zeroed.
    xmit <= 1'b1;
    wr(OFS_IRQ_EN, 8'h08);
    ck(1'b1, 1'b0);
    wr(OFS_IRQ_EN, 8'h00);
    rd(OFS_IRQ_ST, 8'h08);
    xmit <= 1'b0;
    rd(OFS_IRQ_ST, 8'h00);
    // Port flags, enabled with random spare bits and then disabled.
    for (int p = 0; p < 2; p++) begin
      lf = nxt(lf);
      v = {1'b0, lf[6:1], 1'b1};
      ad = p ? OFS_PORT_B : OFS_PORT_A;
      wr(ad, v);
      pin(p);
      ck(1'b1, 1'b0);
      rd(ad, v | 8'h80);
      ck(1'b0, 1'b0);
      rd(ad, v);
      wr(ad, v & 8'hFE);
      pin(p);
      ck(1'b0, 1'b0);
      rd(ad, (v & 8'hFE) | 8'h80);
    end
    // Host side gating of a pending request.
    wr(OFS_IRQ_EN, 8'h01);
    pulse(BIT_TIMER1);
    gie <= 1'b0;
    ck(1'b1, 1'b0);
    ck(1'b1, 1'b0);
    tests_run++;
    if (tk_i !== 1'b0) err("take_irq", 34'h0, tk_i);
    // Opening the global gate again lets the held request through.
    gie <= 1'b1;
    ck(1'b1, 1'b0);
    ck(1'b1, 1'b0);
    tests_run++;
    if (tk_i !== 1'b1) err("take_irq", 34'h1, tk_i);
    wr(OFS_IRQ_EN, 8'h00);
    rd(6'h18, 8'h00);
    wr(6'h18, 8'hFF);
    rd(OFS_IRQ_ST, 8'h00);
    // Nonmaskable path, kept apart from the maskable output.
    pulse(8);
    ck(1'b0, 1'b0);
    wr(OFS_NMI_EN, 8'h01);
    pulse(8);
    ck(1'b0, 1'b1);
    wr(OFS_NMI_EN, 8'h00);
    pin(2);
    ck(1'b0, 1'b1);
    wr(OFS_NMI_ST, 8'h07);
    ck(1'b0, 1'b0);
    // The vertical-blank source is held back until its own enable.
    pulse(9);
    ck(1'b0, 1'b0);
    wr(OFS_NMI_EN, 8'h02);
    ck(1'b0, 1'b1);
    wr(OFS_NMI_ST, 8'h02);
    ck(1'b0, 1'b0);
    stop_test();
  end
endmodule
